// *** src/hpm_pkg.sv ***
// Purpose: Shared constants for the host port pin-function mux
// Assumes: One 20 MHz clock, synchronous active-low reset
// Notes:   Control bit positions are local choices
package hpm_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned CTRL_W      = 16;
  localparam int unsigned GPIO_W      = 16;
  // Control word field positions
  localparam int unsigned CTL_HOST_EN = 0;
  localparam int unsigned CTL_MUXED   = 1;
  localparam int unsigned CTL_STB_POL = 2;
  localparam int unsigned CTL_CS_POL  = 3;
  localparam logic [15:0] CTRL_RST    = 16'h0000;
  localparam logic [15:0] DIR_RST     = 16'h0000;
  // Pin indices of the shared pins
  localparam int unsigned PIN_A0      = 8;
  localparam int unsigned PIN_A1      = 9;
  localparam int unsigned PIN_A2      = 10;
  localparam int unsigned PIN_SEL     = 13;
  // Lines that the gpio function may drive; 11, 12, 14 and 15 lie outside
  localparam logic [15:0] GPIO_LINES  = 16'h27FF;
  // AXI4-Lite register offsets of the host end
  localparam logic [7:0]  OFF_CMD     = 8'h00;
  localparam logic [7:0]  OFF_ADDR    = 8'h04;
  localparam logic [7:0]  OFF_WDATA   = 8'h08;
  localparam logic [7:0]  OFF_RDATA   = 8'h0C;
  localparam logic [7:0]  OFF_STATUS  = 8'h10;
  localparam logic [7:0]  OFF_CFG     = 8'h14;
  // Last count of each host bus phase; a phase lasts one clock more
  localparam logic [3:0]  PHASE_CYC   = 4'h2;
  typedef enum logic [1:0] {HPM_FN_GPIO, HPM_FN_DATA, HPM_FN_MUXED} hpm_fn_t;
  typedef enum logic [1:0] {HPM_RESP_OKAY = 2'b00, HPM_RESP_SLVERR = 2'b10} hpm_resp_t;
endpackage

// *** src/hpm_if.sv ***
// Purpose: Pin-level link between the host port and its host
// Assumes: Each end drives with enable low while driving
// Notes:   Wire levels are resolved by the bench from the enables
`timescale 1ns/10ps
interface hpm_if;
  logic [15:0] dev_pin_o;   // Device pin levels
  logic [15:0] dev_pin_oe_n; // Device enables, low drives
  logic [15:0] host_pin_o;  // Host pin levels
  logic [15:0] host_pin_oe_n; // Host enables, low drives
  logic [15:0] pin_i;       // Resolved wire levels
  modport dev  (output dev_pin_o, output dev_pin_oe_n, input pin_i);
  modport host (output host_pin_o, output host_pin_oe_n, input pin_i);
endinterface

// *** src/hpm_device.sv ***
// Purpose: Host port pin-function selection of the device end
// Assumes: Pins are synchronous to aclk; control from device core
// Notes:   Gpio drives only lines 0-10 and 13; gpio_in samples any of the 16 pins set as input
`timescale 1ns/10ps
module hpm_device (
  input  wire logic        aclk,         // Clock
  input  wire logic        aresetn,      // Sync reset, low active
  hpm_if.dev               link,         // Pin side
  input  wire logic [15:0] ctrl_wr,      // Port control word
  input  wire logic        ctrl_we,      // Control write strobe
  input  wire logic [15:0] dir_wr,       // Direction word
  input  wire logic        dir_we,       // Direction write strobe
  input  wire logic [15:0] gpio_out,     // Gpio output levels
  input  wire logic        stop_mode,    // Core in stop state
  input  wire logic        wait_mode,    // Core in wait state
  input  wire logic [7:0]  rd_data,      // Data returned to host
  output logic      [15:0] gpio_in,      // Sampled gpio inputs
  output logic      [10:0] host_addr,    // Latched host address
  output logic      [7:0]  host_wdata,   // Data written by host
  output logic             host_wr,      // Host write pulse
  output logic             host_rd,      // Host read pulse
  output logic      [15:0] ctrl_q_o,     // Current control word
  output hpm_pkg::hpm_fn_t fn_o          // Current pin function
);
  logic [15:0] ctrl_q, ctrl_d, dir_q, dir_d, gin_q, gin_d;
  logic [15:0] pin_o_q, pin_o_d, oe_n_q, oe_n_d;
  logic [10:0] addr_q, addr_d;
  logic [7:0]  wdata_q, wdata_d;
  logic        wr_q, wr_d, rd_q, rd_d, sel_q, sel_d;
  logic        rst_q;
  hpm_pkg::hpm_fn_t fn;
  logic        sel_act, stb_act, rnw;

  // Reset flag lets inputs be ignored during reset
  always_ff @(posedge aclk) begin
    rst_q <= ~aresetn;
  end

  always_comb begin
    if (!ctrl_q[hpm_pkg::CTL_HOST_EN]) begin
      fn = hpm_pkg::HPM_FN_GPIO;
    end else if (ctrl_q[hpm_pkg::CTL_MUXED]) begin
      fn = hpm_pkg::HPM_FN_MUXED;
    end else begin
      fn = hpm_pkg::HPM_FN_DATA;
    end
  end

  assign sel_act = link.pin_i[hpm_pkg::PIN_SEL] == ctrl_q[hpm_pkg::CTL_CS_POL];
  assign stb_act = link.pin_i[hpm_pkg::PIN_SEL] == ctrl_q[hpm_pkg::CTL_STB_POL];
  // Pin 14 carries read/write: high reads
  assign rnw     = link.pin_i[14];

  always_comb begin
    ctrl_d  = ctrl_q;
    dir_d   = dir_q;
    gin_d   = gin_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    wr_d    = 1'b0;
    rd_d    = 1'b0;
    sel_d   = sel_q;
    pin_o_d = pin_o_q;
    oe_n_d  = 16'hFFFF;
    // wait does not gate any update
    if (ctrl_we) begin
      ctrl_d = ctrl_wr;
    end
    if (dir_we) begin
      dir_d = dir_wr;
    end
    if (!stop_mode && !rst_q) begin
      unique case (fn)
        hpm_pkg::HPM_FN_GPIO: begin
          gin_d = link.pin_i & ~dir_q;
        end
        hpm_pkg::HPM_FN_DATA: begin
          sel_d  = sel_act;
          // address lines 8-10, sampled while selected, held after
          if (sel_act) begin
            addr_d = {8'h00, link.pin_i[hpm_pkg::PIN_A2], link.pin_i[hpm_pkg::PIN_A1],
                      link.pin_i[hpm_pkg::PIN_A0]};
          end
          // data sampled while selected, pulse at release
          // Host may drop data with the select, so keep the last selected sample
          if (sel_act && !rnw) begin
            wdata_d = link.pin_i[7:0];
          end
          if (sel_q && !sel_act && !rnw) begin
            wr_d    = 1'b1;
          end
          if (!sel_q && sel_act && rnw) begin
            rd_d = 1'b1;
          end
        end
        hpm_pkg::HPM_FN_MUXED: begin
          sel_d = stb_act;
          // low address captured while strobe active
          // high address from lines 8-10
          // Data replaces the address on the edge the strobe drops
          if (stb_act) begin
            addr_d = {link.pin_i[hpm_pkg::PIN_A2], link.pin_i[hpm_pkg::PIN_A1],
                      link.pin_i[hpm_pkg::PIN_A0], link.pin_i[7:0]};
          end
          // Data phase framed by pin 12 low
          if (!link.pin_i[12] && !rnw) begin
            wdata_d = link.pin_i[7:0];
            wr_d    = 1'b1;
          end
          if (!link.pin_i[12] && rnw) begin
            rd_d = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    unique case (fn)
      hpm_pkg::HPM_FN_GPIO: begin
        // per-bit direction
        // Host-side control lines 12 and 14 are never driven from here; select pin 13 is a gpio line
        pin_o_d = gpio_out;
        oe_n_d  = ~(dir_q & hpm_pkg::GPIO_LINES);
      end
      hpm_pkg::HPM_FN_DATA: begin
        pin_o_d = {8'h00, rd_data};
        oe_n_d  = (sel_act && rnw) ? 16'hFF00 : 16'hFFFF;
      end
      hpm_pkg::HPM_FN_MUXED: begin
        pin_o_d = {8'h00, rd_data};
        oe_n_d  = (!link.pin_i[12] && rnw) ? 16'hFF00 : 16'hFFFF;
      end
      default: begin
      end
    endcase
    if (rst_q) begin
      oe_n_d = 16'hFFFF;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q  <= hpm_pkg::CTRL_RST;
      dir_q   <= hpm_pkg::DIR_RST;
      gin_q   <= 16'h0000;
      addr_q  <= 11'h000;
      wdata_q <= 8'h00;
      wr_q    <= 1'b0;
      rd_q    <= 1'b0;
      sel_q   <= 1'b0;
      pin_o_q <= 16'h0000;
      oe_n_q  <= 16'hFFFF;
    end else begin
      ctrl_q  <= ctrl_d;
      dir_q   <= dir_d;
      gin_q   <= gin_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      wr_q    <= wr_d;
      rd_q    <= rd_d;
      sel_q   <= sel_d;
      pin_o_q <= pin_o_d;
      oe_n_q  <= oe_n_d;
    end
  end

  assign link.dev_pin_o    = pin_o_q;
  assign link.dev_pin_oe_n = oe_n_q;
  assign gpio_in    = gin_q;
  assign host_addr  = addr_q;
  assign host_wdata = wdata_q;
  assign host_wr    = wr_q;
  assign host_rd    = rd_q;
  assign ctrl_q_o   = ctrl_q;
  assign fn_o       = fn;
endmodule

// *** src/hpm_host.sv ***
// Purpose: External host end driving the host port pins
// Assumes: Software reaches it over AXI4-Lite
// Notes:   One access at a time, started by the command register
`timescale 1ns/10ps
module hpm_host (
  input  wire logic        aclk,     // Clock
  input  wire logic        aresetn,  // Sync reset, low active
  hpm_if.host              link,     // Pin side
  input  wire logic [7:0]  awaddr,   // Write address
  input  wire logic        awvalid,  // Write address valid
  output logic             awready,  // Write address ready
  input  wire logic [31:0] wdata,    // Write data
  input  wire logic [3:0]  wstrb,    // Write strobes
  input  wire logic        wvalid,   // Write data valid
  output logic             wready,   // Write data ready
  output logic      [1:0]  bresp,    // Write response
  output logic             bvalid,   // Write response valid
  input  wire logic        bready,   // Write response ready
  input  wire logic [7:0]  araddr,   // Read address
  input  wire logic        arvalid,  // Read address valid
  output logic             arready,  // Read address ready
  output logic      [31:0] rdata,    // Read data
  output logic      [1:0]  rresp,    // Read response
  output logic             rvalid,   // Read valid
  input  wire logic        rready    // Read ready
);
  typedef enum logic [2:0] {HPM_IDLE, HPM_ADDR, HPM_STB, HPM_DATA, HPM_DONE} hpm_st_t;
  hpm_st_t     st_q, st_d;
  logic [10:0] addr_q, addr_d;
  logic [7:0]  wd_q, wd_d, rd_q, rd_d;
  logic [2:0]  cfg_q, cfg_d;
  logic        rnw_q, rnw_d, busy_q, busy_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [15:0] po_q, po_d, oe_q, oe_d;
  logic        bv_q, bv_d, rv_q, rv_d, go;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rdat_q, rdat_d;
  logic        wr_ok;
  logic        sel_on;
  // Cfg bits: 0 muxed, 1 select/strobe active level
  assign wr_ok   = awvalid && wvalid && !bv_q;
  assign awready = wr_ok;
  assign wready  = wr_ok;
  assign arready = arvalid && !rv_q;
  assign sel_on  = cfg_q[1];

  always_comb begin
    st_d = st_q; addr_d = addr_q; wd_d = wd_q; rd_d = rd_q; cfg_d = cfg_q;
    rnw_d = rnw_q; busy_d = busy_q; cnt_d = cnt_q; po_d = po_q; oe_d = oe_q;
    bv_d = bv_q && !bready; br_d = br_q; rv_d = rv_q && !rready; rr_d = rr_q;
    rdat_d = rdat_q; go = 1'b0;
    if (wr_ok) begin
      bv_d = 1'b1;
      br_d = hpm_pkg::HPM_RESP_OKAY;
      unique case (awaddr)
        hpm_pkg::OFF_CMD:   go = !busy_q;
        hpm_pkg::OFF_ADDR:  addr_d = wdata[10:0];
        hpm_pkg::OFF_WDATA: wd_d = wdata[7:0];
        hpm_pkg::OFF_CFG:   cfg_d = wdata[2:0];
        default:            br_d = hpm_pkg::HPM_RESP_SLVERR;
      endcase
      if (go) begin
        rnw_d = wdata[0]; busy_d = 1'b1; st_d = HPM_ADDR; cnt_d = 4'h0;
      end
    end
    if (arready) begin
      rv_d = 1'b1;
      rr_d = hpm_pkg::HPM_RESP_OKAY;
      unique case (araddr)
        hpm_pkg::OFF_ADDR:   rdat_d = {21'h000000, addr_q};
        hpm_pkg::OFF_WDATA:  rdat_d = {24'h000000, wd_q};
        hpm_pkg::OFF_RDATA:  rdat_d = {24'h000000, rd_q};
        hpm_pkg::OFF_STATUS: rdat_d = {31'h00000000, busy_q};
        hpm_pkg::OFF_CFG:    rdat_d = {29'h00000000, cfg_q};
        default: begin
          rdat_d = 32'h00000000; rr_d = hpm_pkg::HPM_RESP_SLVERR;
        end
      endcase
    end
    // Idle pins: select/strobe and frame inactive, read/write driven, all else released
    po_d = {1'b1, rnw_q, ~sel_on, 1'b1, 12'h000};
    po_d[hpm_pkg::PIN_SEL] = ~sel_on;
    oe_d = 16'hFFFF;
    oe_d[hpm_pkg::PIN_SEL] = 1'b0; oe_d[14] = 1'b0; oe_d[12] = 1'b0;
    if (busy_q) begin
      cnt_d = cnt_q + 4'h1;
    end
    unique case (st_q)
      HPM_IDLE: begin
      end
      HPM_ADDR: begin
        oe_d[hpm_pkg::PIN_A0] = 1'b0; oe_d[hpm_pkg::PIN_A1] = 1'b0;
        oe_d[hpm_pkg::PIN_A2] = 1'b0;
        if (cfg_q[0]) begin
          po_d[10:8] = addr_q[10:8]; po_d[7:0] = addr_q[7:0]; oe_d[7:0] = 8'h00;
          po_d[hpm_pkg::PIN_SEL] = sel_on;
        end else begin
          po_d[10:8] = addr_q[2:0];
        end
        if (cnt_q == hpm_pkg::PHASE_CYC) begin
          st_d = HPM_STB; cnt_d = 4'h0;
        end
      end
      HPM_STB: begin
        oe_d[10:8] = 3'b000;
        po_d[10:8] = cfg_q[0] ? addr_q[10:8] : addr_q[2:0];
        po_d[hpm_pkg::PIN_SEL] = cfg_q[0] ? ~sel_on : sel_on;
        po_d[12] = ~cfg_q[0];
        po_d[7:0] = wd_q; oe_d[7:0] = rnw_q ? 8'hFF : 8'h00;
        if (cnt_q == hpm_pkg::PHASE_CYC) begin
          st_d = HPM_DATA; cnt_d = 4'h0;
        end
      end
      HPM_DATA: begin
        oe_d[10:8] = 3'b000;
        po_d[10:8] = cfg_q[0] ? addr_q[10:8] : addr_q[2:0];
        po_d[hpm_pkg::PIN_SEL] = cfg_q[0] ? ~sel_on : sel_on;
        po_d[12] = ~cfg_q[0];
        po_d[7:0] = wd_q; oe_d[7:0] = rnw_q ? 8'hFF : 8'h00;
        if (cnt_q == hpm_pkg::PHASE_CYC) begin
          rd_d = link.pin_i[7:0]; st_d = HPM_DONE;
        end
      end
      HPM_DONE: begin
        busy_d = 1'b0; st_d = HPM_IDLE;
      end
      default: begin
        busy_d = 1'b0; st_d = HPM_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= HPM_IDLE; addr_q <= 11'h000; wd_q <= 8'h00; rd_q <= 8'h00;
      cfg_q <= 3'h0; rnw_q <= 1'b0; busy_q <= 1'b0; cnt_q <= 4'h0;
      po_q <= 16'h0000; oe_q <= 16'hFFFF; bv_q <= 1'b0; br_q <= 2'b00;
      rv_q <= 1'b0; rr_q <= 2'b00; rdat_q <= 32'h00000000;
    end else begin
      st_q <= st_d; addr_q <= addr_d; wd_q <= wd_d; rd_q <= rd_d;
      cfg_q <= cfg_d; rnw_q <= rnw_d; busy_q <= busy_d; cnt_q <= cnt_d;
      po_q <= po_d; oe_q <= oe_d; bv_q <= bv_d; br_q <= br_d;
      rv_q <= rv_d; rr_q <= rr_d; rdat_q <= rdat_d;
    end
  end

  assign link.host_pin_o    = po_q;
  assign link.host_pin_oe_n = oe_q;
  assign bvalid = bv_q;
  assign bresp  = br_q;
  assign rvalid = rv_q;
  assign rresp  = rr_q;
  assign rdata  = rdat_q;
endmodule

// *** verification/hpm_checker.sv ***
// Purpose: Pin-level checks between host and device ends
// Assumes: Host runs accesses only while the device is in host mode
// Notes:   Watches the interface signals only
`timescale 1ns/10ps
module hpm_checker (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Sync reset, low active
  input wire logic [15:0] dev_pin_o,     // Device levels
  input wire logic [15:0] dev_pin_oe_n,  // Device enables
  input wire logic [15:0] host_pin_o,    // Host levels
  input wire logic [15:0] host_pin_oe_n, // Host enables
  input wire logic [15:0] pin_i          // Wire levels
);
  sequence rst_release_s;
    !aresetn ##1 aresetn;
  endsequence
  rst_quiet_a: assert property (
    @(posedge aclk) !aresetn |=> &dev_pin_oe_n && &host_pin_oe_n)
    else $error("pins driven in reset");
  release_quiet_a: assert property (
    @(posedge aclk) rst_release_s |=> &dev_pin_oe_n)
    else $error("device drove right after reset");
  data_clash_a: assert property (
    @(posedge aclk) disable iff (!aresetn) (dev_pin_oe_n[7:0] | host_pin_oe_n[7:0]) == 8'hFF)
    else $error("both ends drive data");
  addr_clash_a: assert property (
    @(posedge aclk) disable iff (!aresetn) (dev_pin_oe_n[10:8] | host_pin_oe_n[10:8]) == 3'h7)
    else $error("both ends drive address");
  host_ctl_a: assert property (
    @(posedge aclk) disable iff (!aresetn) $past(aresetn) |-> host_pin_oe_n[14:12] == 3'h0)
    else $error("host left select lines");
  dev_fixed_a: assert property (
    @(posedge aclk) disable iff (!aresetn) dev_pin_oe_n[15:14] == 2'h3 && dev_pin_oe_n[12:11] == 2'h3)
    else $error("device drove a non-gpio line");
  host_byte_a: assert property (
    @(posedge aclk) disable iff (!aresetn) host_pin_oe_n[7:0] inside {8'h00, 8'hFF})
    else $error("host split the data byte");
  host_addr_a: assert property (
    @(posedge aclk) disable iff (!aresetn) host_pin_oe_n[10:8] inside {3'h0, 3'h7})
    else $error("host split the address lines");
endmodule

// *** verification/tb.sv ***
// Purpose: Self-checking bench joining host and device ends
// Assumes: Undriven wire floats high through a pull-up
// Notes:   Bench drives gpio inputs as a third party on the wire
`timescale 1ns/10ps
module tb;
  logic             aclk, aresetn = 1'b0, ctrl_we = 1'b0, dir_we = 1'b0;
  logic             stop_mode = 1'b0, wait_mode = 1'b0, host_wr, host_rd;
  logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, awready, wready, bvalid;
  logic             arvalid = 1'b0, rready = 1'b0, arready, rvalid;
  logic [15:0]      ctrl_wr = 16'h0000, dir_wr = 16'h0000, gpio_out = 16'h00A5;
  logic [15:0]      tb_o = 16'h0500, tb_oe_n = 16'hF8FF, gpio_in, ctrl_q_o;
  logic [10:0]      host_addr, cap_addr, m;
  logic [7:0]       rd_data = 8'h00, awaddr = 8'h00, araddr = 8'h00, host_wdata, cap_wdata;
  logic [31:0]      wdata = 32'h0, rdata, v;
  logic [3:0]       wstrb = 4'hF;
  logic [1:0]       bresp, rresp, r;
  hpm_pkg::hpm_fn_t fn_o;
  int               fail_count, num_checks, cyc, wr_cnt, rd_cnt, n0;
  localparam logic [15:0] MC [4] = '{16'h0001, 16'h0009, 16'h0003, 16'h0007};
  localparam logic [1:0]  HC [4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  localparam logic [10:0] AD [4] = '{11'h005, 11'h002, 11'h5A7, 11'h6DB};
  localparam logic [7:0]  DD [4] = '{8'h5A, 8'hC3, 8'h3E, 8'h81};
  hpm_if i_hpm_if ();
  // Pull-up wins only where nobody drives
  assign i_hpm_if.pin_i = (i_hpm_if.dev_pin_oe_n & i_hpm_if.host_pin_oe_n & tb_oe_n)
    | (~i_hpm_if.dev_pin_oe_n & i_hpm_if.dev_pin_o) | (~tb_oe_n & tb_o)
    | (~i_hpm_if.host_pin_oe_n & i_hpm_if.host_pin_o);
  hpm_device i_hpm_device (.aclk, .aresetn, .link(i_hpm_if), .ctrl_wr, .ctrl_we, .dir_wr,
    .dir_we, .gpio_out, .stop_mode, .wait_mode, .rd_data, .gpio_in, .host_addr,
    .host_wdata, .host_wr, .host_rd, .ctrl_q_o, .fn_o);
  hpm_host i_hpm_host (.aclk, .aresetn, .link(i_hpm_if), .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready);
  hpm_checker i_hpm_checker (.aclk, .aresetn, .dev_pin_o(i_hpm_if.dev_pin_o),
    .dev_pin_oe_n(i_hpm_if.dev_pin_oe_n), .host_pin_o(i_hpm_if.host_pin_o),
    .host_pin_oe_n(i_hpm_if.host_pin_oe_n), .pin_i(i_hpm_if.pin_i));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (!(awready === 1'b1 && wready === 1'b1));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic acc(input logic [10:0] a, input logic [7:0] d, input logic is_rd);
    wr(hpm_pkg::OFF_ADDR, {21'h0, a});
    wr(hpm_pkg::OFF_WDATA, {24'h0, d});
    wr(hpm_pkg::OFF_CMD, {31'h0, is_rd});
    do rd(hpm_pkg::OFF_STATUS); while (v[0] !== 1'b0);
  endtask
  task automatic setc(input logic [15:0] c, input logic [15:0] dr);
    @(posedge aclk);
    ctrl_wr <= c;
    dir_wr <= dr;
    ctrl_we <= 1'b1;
    dir_we <= 1'b1;
    @(posedge aclk);
    ctrl_we <= 1'b0;
    dir_we <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (host_wr === 1'b1) begin
      cap_addr <= host_addr;
      cap_wdata <= host_wdata;
      wr_cnt <= wr_cnt + 1;
    end
    if (host_rd === 1'b1) rd_cnt <= rd_cnt + 1;
    // Hang guard, far above the few hundred cycles needed
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("ctrl", hpm_pkg::CTRL_RST, ctrl_q_o);
    chk("fn", hpm_pkg::HPM_FN_GPIO, fn_o);
    setc(16'h0000, 16'h00FF);
    chk("pins", 32'hA5, i_hpm_if.pin_i[7:0]);
    chk("gpio_in", 32'h2500, gpio_in & 16'h27FF);
    tb_o <= 16'h003C;
    tb_oe_n <= 16'hFB00;
    gpio_out <= 16'h0200;
    setc(16'h0000, 16'h0300);
    chk("pins", 32'h2, i_hpm_if.pin_i[9:8]);
    chk("gpio_in", 32'h203C, gpio_in & 16'h27FF);
    stop_mode <= 1'b1;
    tb_o <= 16'h00C3;
    repeat (3) @(posedge aclk);
    chk("gpio_in", 32'h203C, gpio_in & 16'h27FF);
    stop_mode <= 1'b0;
    wait_mode <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("gpio_in", 32'h20C3, gpio_in & 16'h27FF);
    chk("pins", 32'h2, i_hpm_if.pin_i[9:8]);
    wait_mode <= 1'b0;
    tb_oe_n <= 16'hFFFF;
    for (int i = 0; i < 4; i++) begin
      // Direction all outputs: host mode must override it
      setc(MC[i], 16'hFFFF);
      wr(hpm_pkg::OFF_CFG, {30'h0, HC[i]});
      chk("fn", MC[i][1] ? hpm_pkg::HPM_FN_MUXED : hpm_pkg::HPM_FN_DATA, fn_o);
      chk("addr_oe", 32'h7, i_hpm_if.dev_pin_oe_n[10:8]);
      m = MC[i][1] ? 11'h7FF : 11'h007;
      n0 = wr_cnt;
      acc(AD[i], DD[i], 1'b0);
      chk("wr_seen", 32'h1, wr_cnt > n0);
      chk("host_addr", AD[i] & m, cap_addr & m);
      chk("host_wdata", DD[i], cap_wdata);
      rd_data <= ~DD[i];
      n0 = rd_cnt;
      acc(AD[i], 8'h00, 1'b1);
      chk("rd_seen", 32'h1, rd_cnt > n0);
      rd(hpm_pkg::OFF_RDATA);
      chk("rdata", {24'h0, ~DD[i]}, v);
    end
    wr(8'h40, 32'h1);
    chk("bresp", hpm_pkg::HPM_RESP_SLVERR, r);
    rd(8'h40);
    chk("rresp", hpm_pkg::HPM_RESP_SLVERR, r);
    chk("rdata", 32'h0, v);
    end_of_test();
  end
endmodule
